// ### common/fioc_pkg.sv
// constants and types shared by the overflow-check back end
package fioc_pkg;

	// ----------------------------------------------------------------
	// datapath widths
	// ----------------------------------------------------------------
	localparam int EXP_W      = 16;
	localparam int BEXP_W     = 15;
	localparam int MANT_IN_W  = 67;
	localparam int MANT_OUT_W = 64;
	localparam int CMD_W      = 16;
	localparam int ADDR_W     = 32;
	localparam int REG_AW     = 8;
	localparam int DATA_W     = 32;
	localparam int EXC_W      = 3;

	// ----------------------------------------------------------------
	// rounding precision encodings and their mantissa widths
	// ----------------------------------------------------------------
	localparam logic [1:0] ROUNDING_PRECISION_FIELD_EXT = 2'h0;
	localparam logic [1:0] ROUNDING_PRECISION_FIELD_SGL = 2'h1;
	localparam logic [1:0] ROUNDING_PRECISION_FIELD_DBL = 2'h2;
	localparam int ROUNDING_PRECISION_FIELD_EXT_BITS = 64;
	localparam int ROUNDING_PRECISION_FIELD_DBL_BITS = 53;
	localparam int ROUNDING_PRECISION_FIELD_SGL_BITS = 24;
	localparam logic [6:0] RND_LSB_EXT = 7'(MANT_IN_W - ROUNDING_PRECISION_FIELD_EXT_BITS);
	localparam logic [6:0] RND_LSB_DBL = 7'(MANT_IN_W - ROUNDING_PRECISION_FIELD_DBL_BITS);
	localparam logic [6:0] RND_LSB_SGL = 7'(MANT_IN_W - ROUNDING_PRECISION_FIELD_SGL_BITS);

	// ----------------------------------------------------------------
	// unbiased exponent limits, extended bias
	// ----------------------------------------------------------------
	localparam logic [15:0] EXT_BIAS    = 16'h3fff;
	localparam logic [15:0] EXP_MAX_EXT = 16'h4000;
	localparam logic [15:0] EXP_MAX_DBL = 16'h0400;
	localparam logic [15:0] EXP_MAX_SGL = 16'h0080;
	localparam logic [15:0] EXP_MIN_EXT = 16'hc002;
	localparam logic [15:0] EXP_MIN_DBL = 16'hfc02;
	localparam logic [15:0] EXP_MIN_SGL = 16'hff82;
	localparam logic [15:0] EXP_MAX_INT = 16'h001f;
	localparam logic [15:0] EXP_ONE     = 16'h0001;

	// ----------------------------------------------------------------
	// destination kinds and formats
	// ----------------------------------------------------------------
	localparam logic [1:0] DST_FPREG  = 2'h0;
	localparam logic [1:0] DST_MEM    = 2'h1;
	localparam logic [1:0] DST_INTREG = 2'h2;
	localparam logic [2:0] FMT_SGL    = 3'h0;
	localparam logic [2:0] FMT_DBL    = 3'h1;
	localparam logic [2:0] FMT_EXT    = 3'h2;
	localparam logic [3:0] FRAME_FMT_NONE  = 4'h0;
	localparam logic [3:0] FRAME_FMT_OPERAND_ERROR_EXCEPTION = 4'h3;

	// ----------------------------------------------------------------
	// register map and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_CLEAR  = 8'h08;
	localparam logic [7:0] OFF_ENABLE = 8'h0c;
	localparam logic [7:0] OFF_CMD    = 8'h10;
	localparam logic [7:0] OFF_EA     = 8'h14;
	localparam logic [7:0] OFF_IADDR  = 8'h18;
	localparam int EXC_OPERAND_ERROR_EXCEPTION_BIT = 0;
	localparam int EXC_UNFL_BIT  = 1;
	localparam int EXC_OVERFLOW_FLAG_BIT  = 2;
	localparam logic [1:0] CTRL_ROUNDING_PRECISION_FIELD_RST = ROUNDING_PRECISION_FIELD_EXT;
	localparam logic [2:0] EXC_RST       = 3'h0;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_UNFL  = 5'h02,
		ST_ROUND = 5'h04,
		ST_OVERFLOW_FLAG  = 5'h08,
		ST_EXCW  = 5'h10
	} fioc_state_e;

endpackage : fioc_pkg

// ### hdl/fioc_rounder.sv
// round-to-nearest-even mantissa rounder with registered result
`timescale 1ns/10ps
module fioc_rounder
	import fioc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  start,
	input  wire logic [MANT_IN_W-1:0]  mant_in,
	input  wire logic [EXP_W-1:0]      exp_in,
	input  wire logic [1:0]            rounding_precision_field_in,
	output logic                       done_q,
	output logic [MANT_OUT_W-1:0]      mant_q,
	output logic [EXP_W-1:0]           exp_q
);

	typedef struct packed {
		logic                  done;
		logic [MANT_OUT_W-1:0] mant;
		logic [EXP_W-1:0]      exp;
	} fioc_rnd_s;

	fioc_rnd_s q, n;
	logic [MANT_IN_W:0] one, below, ext_in, trunc, sum;
	logic               rnd;

	function automatic logic [6:0] lsb_pos(input logic [1:0] p);
		case (p)
			ROUNDING_PRECISION_FIELD_SGL: lsb_pos = RND_LSB_SGL;
			ROUNDING_PRECISION_FIELD_DBL: lsb_pos = RND_LSB_DBL;
			default:  lsb_pos = RND_LSB_EXT;
		endcase
	endfunction : lsb_pos

	// ----------------------------------------------------------------
	// rounding
	// ----------------------------------------------------------------
	always_comb begin
		n      = q;
		n.done = start;
		ext_in = {1'b0, mant_in};
		one    = (MANT_IN_W+1)'(1) << lsb_pos(rounding_precision_field_in);
		below  = one - (MANT_IN_W+1)'(1);
		// bits below the precision are forced to zero
		trunc  = ext_in & ~below;
		// guard set and (sticky or odd lsb) rounds up
		rnd    = (|(ext_in & (one >> 1))) && ((|(ext_in & (below >> 1))) || (|(ext_in & one)));
		sum    = rnd ? trunc + one : trunc;
		if (start) begin
			if (sum[MANT_IN_W]) begin
				// carry out renormalises; lower bits are all zero here
				n.mant = sum[MANT_IN_W:MANT_IN_W-MANT_OUT_W+1];
				n.exp  = exp_in + EXP_ONE;
			end else begin
				n.mant = sum[MANT_IN_W-1:MANT_IN_W-MANT_OUT_W];
				n.exp  = exp_in;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign done_q = q.done;
	assign mant_q = q.mant;
	assign exp_q  = q.exp;

endmodule : fioc_rounder

// ### hdl/fioc_overflow_flag_check.sv
// floating-point back end: underflow check, rounding, overflow check, store
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps

// Functional notes
// - intermediate exponent is a 16-bit twos-complement integer
// - exponent is converted to 15-bit biased form before register store
// - 67-bit mantissa kept, rounded to at most 64 bits
// - register results in extended format, bits below precision forced zero
// - overflow when exponent reaches the selected precision maximum
// - only single, double, extended overflow; other formats raise operand error
// - order: underflow check, round, overflow check, then store
// - overflow sets the overflow bit of the exception status byte
// - overflow against rounding precision even if extended would fit
// - overflow exception is nonmaskable and always taken
// - register destination left unchanged on overflow, exception reported
// - memory or integer destination written, post-instruction exception at once
// - operand error records the command in the saved frame field
// - operand error to memory supplies effective address, frame format 3
// - instruction address register points at the instruction word
module fioc_overflow_flag_check
	import fioc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  op_valid,
	input  wire logic                  op_sign,
	input  wire logic [EXP_W-1:0]      op_exp,
	input  wire logic [MANT_IN_W-1:0]  op_mant,
	input  wire logic [1:0]            op_dest,
	input  wire logic [2:0]            op_fmt,
	input  wire logic [CMD_W-1:0]      op_cmd,
	input  wire logic [ADDR_W-1:0]     op_ea,
	input  wire logic [ADDR_W-1:0]     op_iaddr,
	input  wire logic                  exc_ack,
	input  wire logic [REG_AW-1:0]     reg_addr,
	input  wire logic [DATA_W-1:0]     reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic                       op_ready_q,
	output logic                       res_wr_q,
	output logic [1:0]                 res_dest_q,
	output logic                       res_sign_q,
	output logic [BEXP_W-1:0]          res_exp_q,
	output logic [MANT_OUT_W-1:0]      res_mant_q,
	output logic                       overflow_flag_exc_q,
	output logic                       operand_error_exception_exc_q,
	output logic                       exc_post_q,
	output logic [3:0]                 frame_fmt_q,
	output logic                       irq_q,
	output logic [DATA_W-1:0]          reg_rdata_q
);

	typedef struct packed {
		fioc_state_e           st;
		logic [1:0]            ctrl_rounding_precision_field;
		logic [EXC_W-1:0]      exception_status_byte;
		logic [EXC_W-1:0]      en;
		logic [CMD_W-1:0]      cmd;
		logic [ADDR_W-1:0]     ea;
		logic [ADDR_W-1:0]     iaddr;
		logic [ADDR_W-1:0]     op_ea;
		logic                  sign;
		logic [EXP_W-1:0]      exp;
		logic [MANT_IN_W-1:0]  mant;
		logic [1:0]            dest;
		logic [2:0]            fmt;
		logic [1:0]            psel;
		logic [EXP_W-1:0]      rexp;
		logic [MANT_OUT_W-1:0] rmant;
		logic                  ready;
		logic                  res_wr;
		logic [1:0]            res_dest;
		logic                  res_sign;
		logic [BEXP_W-1:0]     res_exp;
		logic [MANT_OUT_W-1:0] res_mant;
		logic                  overflow_flag_exc;
		logic                  operand_error_exception_exc;
		logic                  exc_post;
		logic [3:0]            frame_fmt;
		logic                  irq;
		logic [DATA_W-1:0]     rdata;
	} fioc_state_s;

	fioc_state_s            q, n;
	logic                   rnd_start;
	logic                   rnd_done;
	logic [MANT_OUT_W-1:0]  rnd_mant;
	logic [EXP_W-1:0]       rnd_exp;
	logic                   overflow_flag_now;
	logic                   operand_error_exception_now;
	logic [EXC_W-1:0]       exc_set;
	logic [EXC_W-1:0]       exc_clr;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] exp_max(input logic [1:0] p);
		case (p)
			ROUNDING_PRECISION_FIELD_SGL: exp_max = EXP_MAX_SGL;
			ROUNDING_PRECISION_FIELD_DBL: exp_max = EXP_MAX_DBL;
			default:  exp_max = EXP_MAX_EXT;
		endcase
	endfunction : exp_max

	function automatic logic [15:0] exp_min(input logic [1:0] p);
		case (p)
			ROUNDING_PRECISION_FIELD_SGL: exp_min = EXP_MIN_SGL;
			ROUNDING_PRECISION_FIELD_DBL: exp_min = EXP_MIN_DBL;
			default:  exp_min = EXP_MIN_EXT;
		endcase
	endfunction : exp_min

	function automatic logic is_float(input logic [2:0] f);
		is_float = (f == FMT_SGL) || (f == FMT_DBL) || (f == FMT_EXT);
	endfunction : is_float

	// register destinations round to the control precision, others to their format, non-float formats to extended
	function automatic logic [1:0] rounding_precision_field_sel(input logic [1:0] d, input logic [2:0] f,
			input logic [1:0] c);
		if (d == DST_FPREG) begin
			rounding_precision_field_sel = c;
		end else begin
			case (f)
				FMT_SGL: rounding_precision_field_sel = ROUNDING_PRECISION_FIELD_SGL;
				FMT_DBL: rounding_precision_field_sel = ROUNDING_PRECISION_FIELD_DBL;
				default: rounding_precision_field_sel = ROUNDING_PRECISION_FIELD_EXT;
			endcase
		end
	endfunction : rounding_precision_field_sel

	// ----------------------------------------------------------------
	// rounder
	// ----------------------------------------------------------------
	fioc_rounder u_rounder (
		.clk     (clk),
		.rst     (rst),
		.start   (rnd_start),
		.mant_in (q.mant),
		.exp_in  (q.exp),
		.rounding_precision_field_in (q.psel),
		.done_q  (rnd_done),
		.mant_q  (rnd_mant),
		.exp_q   (rnd_exp)
	);

	assign rnd_start = (q.st == ST_UNFL);

	// ----------------------------------------------------------------
	// overflow and operand-error decision on the rounded result
	// ----------------------------------------------------------------
	always_comb begin
		overflow_flag_now  = 1'b0;
		operand_error_exception_now = 1'b0;
		if (q.dest == DST_FPREG || is_float(q.fmt)) begin
			overflow_flag_now = $signed(q.rexp) >= $signed(exp_max(q.psel));
		end else begin
			operand_error_exception_now = $signed(q.rexp) >= $signed(EXP_MAX_INT);
		end
	end

	// ----------------------------------------------------------------
	// sequencer and register file
	// ----------------------------------------------------------------
	always_comb begin
		n         = q;
		n.res_wr  = 1'b0;
		exc_set   = '0;
		exc_clr   = '0;
		case (q.st)
			ST_IDLE: begin
				if (op_valid) begin
					n.sign  = op_sign;
					n.exp   = op_exp;
					n.mant  = op_mant;
					n.dest  = op_dest;
					n.fmt   = op_fmt;
					n.op_ea = op_ea;
					n.psel  = rounding_precision_field_sel(op_dest, op_fmt, q.ctrl_rounding_precision_field);
					n.cmd   = op_cmd;
					n.iaddr = op_iaddr;
					n.st    = ST_UNFL;
				end
			end
			ST_UNFL: begin
				// underflow is checked on the unrounded exponent
				exc_set[EXC_UNFL_BIT] = $signed(q.exp) < $signed(exp_min(q.psel));
				n.st = ST_ROUND;
			end
			ST_ROUND: begin
				if (rnd_done) begin
					n.rexp  = rnd_exp;
					n.rmant = rnd_mant;
					n.st    = ST_OVERFLOW_FLAG;
				end
			end
			ST_OVERFLOW_FLAG: begin
				n.res_sign = q.sign;
				n.res_dest = q.dest;
				n.res_exp  = BEXP_W'(q.rexp + EXT_BIAS);
				n.res_mant = q.rmant;
				n.frame_fmt = FRAME_FMT_NONE;
				if (overflow_flag_now) begin
					exc_set[EXC_OVERFLOW_FLAG_BIT] = 1'b1;
					n.overflow_flag_exc = 1'b1;
					// a register destination keeps its old value
					n.res_wr   = (q.dest != DST_FPREG);
					n.exc_post = (q.dest != DST_FPREG);
					n.st       = ST_EXCW;
				end else if (operand_error_exception_now) begin
					exc_set[EXC_OPERAND_ERROR_EXCEPTION_BIT] = 1'b1;
					n.operand_error_exception_exc = 1'b1;
					n.res_wr    = 1'b1;
					n.exc_post  = 1'b1;
					if (q.dest == DST_MEM) begin
						n.ea        = q.op_ea;
						n.frame_fmt = FRAME_FMT_OPERAND_ERROR_EXCEPTION;
					end
					n.st = ST_EXCW;
				end else begin
					n.res_wr = 1'b1;
					n.st     = ST_IDLE;
				end
			end
			ST_EXCW: begin
				// no new operation is accepted until the sequencer takes the exception
				if (exc_ack) begin
					n.overflow_flag_exc  = 1'b0;
					n.operand_error_exception_exc = 1'b0;
					n.exc_post  = 1'b0;
					n.st        = ST_IDLE;
				end
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase

		if (reg_wr) begin
			case (reg_addr)
				OFF_CTRL:   n.ctrl_rounding_precision_field = reg_wdata[1:0];
				OFF_CLEAR:  exc_clr     = reg_wdata[EXC_W-1:0];
				OFF_ENABLE: n.en        = reg_wdata[EXC_W-1:0];
				default:    n.en        = n.en;
			endcase
		end
		// a flag raised in the clearing cycle survives
		n.exception_status_byte   = (q.exception_status_byte & ~exc_clr) | exc_set;
		n.irq   = |(n.exception_status_byte & n.en);
		n.ready = (n.st == ST_IDLE);

		n.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				OFF_CTRL:   n.rdata = DATA_W'(q.ctrl_rounding_precision_field);
				OFF_STATUS: n.rdata = DATA_W'(q.exception_status_byte);
				OFF_ENABLE: n.rdata = DATA_W'(q.en);
				OFF_CMD:    n.rdata = DATA_W'(q.cmd);
				OFF_EA:     n.rdata = q.ea;
				OFF_IADDR:  n.rdata = q.iaddr;
				default:    n.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q           <= '0;
			q.st        <= ST_IDLE;
			q.ctrl_rounding_precision_field <= CTRL_ROUNDING_PRECISION_FIELD_RST;
			q.exception_status_byte       <= EXC_RST;
			q.en        <= EXC_RST;
			q.ready     <= 1'b1;
			q.frame_fmt <= FRAME_FMT_NONE;
		end else begin
			q <= n;
		end
	end

	assign op_ready_q  = q.ready;
	assign res_wr_q    = q.res_wr;
	assign res_dest_q  = q.res_dest;
	assign res_sign_q  = q.res_sign;
	assign res_exp_q   = q.res_exp;
	assign res_mant_q  = q.res_mant;
	assign overflow_flag_exc_q  = q.overflow_flag_exc;
	assign operand_error_exception_exc_q = q.operand_error_exception_exc;
	assign exc_post_q  = q.exc_post;
	assign frame_fmt_q = q.frame_fmt;
	assign irq_q       = q.irq;
	assign reg_rdata_q = q.rdata;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_overflow_flag_req_flag: assert property (
		(q.st == ST_OVERFLOW_FLAG && overflow_flag_now) |=> (overflow_flag_exc_q && q.exception_status_byte[EXC_OVERFLOW_FLAG_BIT]))
		else $error("overflow check did not raise request and flag");
	a_fpreg_kept: assert property (
		$rose(overflow_flag_exc_q) && res_dest_q == DST_FPREG |-> !res_wr_q && !exc_post_q)
		else $error("register destination written on overflow");
	a_mem_post_write: assert property (
		$rose(overflow_flag_exc_q) && res_dest_q != DST_FPREG |-> res_wr_q && exc_post_q)
		else $error("memory or integer overflow not written with post exception");
	a_exc_held: assert property (
		overflow_flag_exc_q && !exc_ack |=> overflow_flag_exc_q)
		else $error("overflow request dropped before acknowledge");
	a_no_write_wait: assert property (
		q.st == ST_EXCW |=> !res_wr_q && !(op_ready_q && $past(!exc_ack)))
		else $error("write or accept while exception pending");
	a_round_order: assert property (
		q.st == ST_UNFL |=> q.st == ST_ROUND ##1 q.st == ST_OVERFLOW_FLAG)
		else $error("check, round, check order broken");
	a_sgl_low_zero: assert property (
		q.st == ST_OVERFLOW_FLAG && q.psel == ROUNDING_PRECISION_FIELD_SGL |=> res_mant_q[MANT_OUT_W-ROUNDING_PRECISION_FIELD_SGL_BITS-1:0] == '0)
		else $error("mantissa bits below single precision not zero");
	a_exp_biased: assert property (
		q.st == ST_OVERFLOW_FLAG |=> res_exp_q == BEXP_W'($past(q.rexp) + EXT_BIAS))
		else $error("biased exponent conversion wrong");
	a_cmd_saved: assert property (
		q.st == ST_IDLE && op_valid |=> q.cmd == $past(op_cmd))
		else $error("command not recorded");
	a_operand_error_exception_frame: assert property (
		$rose(operand_error_exception_exc_q) && res_dest_q == DST_MEM |-> frame_fmt_q == FRAME_FMT_OPERAND_ERROR_EXCEPTION)
		else $error("operand error frame format wrong");

	c_overflow_flag_fpreg: cover property ($rose(overflow_flag_exc_q) && res_dest_q == DST_FPREG);
	c_overflow_flag_mem:   cover property ($rose(overflow_flag_exc_q) && res_dest_q == DST_MEM);
	c_operand_error_exception_int:  cover property ($rose(operand_error_exception_exc_q) && res_dest_q == DST_INTREG);
	c_clean_store: cover property (res_wr_q && !overflow_flag_exc_q && !operand_error_exception_exc_q);

endmodule : fioc_overflow_flag_check

// ### verification/fpu_intermediate_overflow_check_test.sv
// self-checking bench for the overflow-check back end
`timescale 1ns/10ps
module fpu_intermediate_overflow_check_test
	import fioc_pkg::*;
;
	logic                 clk;
	logic                 rst;
	logic                 op_valid;
	logic                 op_sign;
	logic [EXP_W-1:0]     op_exp;
	logic [MANT_IN_W-1:0] op_mant;
	logic [1:0]           op_dest;
	logic [2:0]           op_fmt;
	logic [CMD_W-1:0]     op_cmd;
	logic [ADDR_W-1:0]    op_ea;
	logic [ADDR_W-1:0]    op_iaddr;
	logic                 exc_ack;
	logic [REG_AW-1:0]    reg_addr;
	logic [DATA_W-1:0]    reg_wdata;
	logic                 reg_wr;
	logic                 reg_rd;
	logic                 op_ready_q;
	logic                 res_wr_q;
	logic [1:0]           res_dest_q;
	logic                 res_sign_q;
	logic [BEXP_W-1:0]    res_exp_q;
	logic [MANT_OUT_W-1:0] res_mant_q;
	logic                 overflow_flag_exc_q;
	logic                 operand_error_exception_exc_q;
	logic                 exc_post_q;
	logic [3:0]           frame_fmt_q;
	logic                 irq_q;
	logic [DATA_W-1:0]    reg_rdata_q;
	int                   num_errors;
	int                   tests_run;
	int                   cycles;
	logic [DATA_W-1:0]    rd;

	fioc_overflow_flag_check dut_u (.clk(clk), .rst(rst), .op_valid(op_valid), .op_sign(op_sign),
		.op_exp(op_exp), .op_mant(op_mant), .op_dest(op_dest), .op_fmt(op_fmt),
		.op_cmd(op_cmd), .op_ea(op_ea), .op_iaddr(op_iaddr), .exc_ack(exc_ack),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.op_ready_q(op_ready_q), .res_wr_q(res_wr_q), .res_dest_q(res_dest_q),
		.res_sign_q(res_sign_q), .res_exp_q(res_exp_q), .res_mant_q(res_mant_q),
		.overflow_flag_exc_q(overflow_flag_exc_q), .operand_error_exception_exc_q(operand_error_exception_exc_q), .exc_post_q(exc_post_q),
		.frame_fmt_q(frame_fmt_q), .irq_q(irq_q), .reg_rdata_q(reg_rdata_q));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [63:0] expv, input logic [63:0] got);
		tests_run++;
		if (got !== expv) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, expv, got);
		end
	endtask : chk

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_q;
	endtask : reg_read

	// returns one step after the edge that carries the answer (cycle 4)
	task automatic run_op(input logic [1:0] d, input logic [2:0] f, input logic [15:0] e,
			input logic [66:0] m);
		@(posedge clk);
		op_dest <= d;
		op_fmt <= f;
		op_exp <= e;
		op_mant <= m;
		op_valid <= 1'b1;
		@(posedge clk);
		op_valid <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("op_ready_q busy", 1'b0, op_ready_q);
		@(posedge clk);
		#1;
	endtask : run_op

	// holds off, proves the request stays, then acknowledges
	task automatic take_exc();
		repeat (3) @(posedge clk);
		#1;
		chk("op_ready_q pending", 1'b0, op_ready_q);
		chk("res_wr_q pending", 1'b0, res_wr_q);
		chk("request held", 1'b1, overflow_flag_exc_q | operand_error_exception_exc_q);
		@(posedge clk);
		exc_ack <= 1'b1;
		@(posedge clk);
		exc_ack <= 1'b0;
		#1;
		chk("overflow_flag_exc_q acked", 1'b0, overflow_flag_exc_q);
		chk("operand_error_exception_exc_q acked", 1'b0, operand_error_exception_exc_q);
		chk("op_ready_q acked", 1'b1, op_ready_q);
	endtask : take_exc

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk("op_ready_q reset", 1'b1, op_ready_q);
		chk("overflow_flag_exc_q reset", 1'b0, overflow_flag_exc_q);
		chk("irq_q reset", 1'b0, irq_q);
		reg_read(OFF_CTRL, rd);
		chk("ctrl reset", 32'h0000_0000, rd);
		reg_read(OFF_STATUS, rd);
		chk("status reset", 32'h0000_0000, rd);
		reg_read(8'h20, rd);
		chk("unmapped read", 32'h0000_0000, rd);
	endtask : t_reset

	// extended rounding up, then single precision masking of low bits
	task automatic t_round();
		op_sign <= 1'b1;
		run_op(DST_FPREG, FMT_EXT, 16'h0000, 67'h4_0000_0000_0000_0005);
		chk("res_wr_q ext", 1'b1, res_wr_q);
		chk("res_sign_q", 1'b1, res_sign_q);
		chk("res_exp_q ext", 15'h3fff, res_exp_q);
		chk("res_mant_q ext", 64'h8000_0000_0000_0001, res_mant_q);
		@(posedge clk);
		#1;
		chk("res_wr_q pulse", 1'b0, res_wr_q);
		op_sign <= 1'b0;
		reg_write(OFF_CTRL, 32'h0000_0001);
		run_op(DST_FPREG, FMT_EXT, 16'hfff0, 67'h4_0000_03ff_ffff_ffff);
		chk("res_exp_q sgl", 15'h3fef, res_exp_q);
		chk("res_mant_q sgl", 64'h8000_0000_0000_0000, res_mant_q);
		chk("overflow_flag below max", 1'b0, overflow_flag_exc_q);
	endtask : t_round

	// single precision: overflow only after rounding carries to 2^128
	task automatic t_overflow_flag_reg();
		reg_write(OFF_ENABLE, 32'h0000_0000);
		run_op(DST_FPREG, FMT_EXT, 16'h007f, 67'h7_ffff_ffff_ffff_ffff);
		chk("overflow_flag_exc_q reg", 1'b1, overflow_flag_exc_q);
		chk("res_wr_q reg", 1'b0, res_wr_q);
		chk("exc_post_q reg", 1'b0, exc_post_q);
		take_exc();
		reg_read(OFF_STATUS, rd);
		chk("status overflow_flag", 32'h0000_0004, rd);
		chk("irq_q masked", 1'b0, irq_q);
		reg_write(OFF_STATUS, 32'h0000_0000);
		reg_write(OFF_ENABLE, 32'h0000_0004);
		repeat (2) @(posedge clk);
		#1;
		chk("irq_q enabled", 1'b1, irq_q);
		reg_read(OFF_ENABLE, rd);
		chk("enable read", 32'h0000_0004, rd);
		reg_write(OFF_CLEAR, 32'h0000_0007);
		repeat (2) @(posedge clk);
		#1;
		chk("irq_q cleared", 1'b0, irq_q);
		reg_read(OFF_STATUS, rd);
		chk("status cleared", 32'h0000_0000, rd);
		reg_write(OFF_CTRL, 32'h0000_0000);
	endtask : t_overflow_flag_reg

	// memory uses its own format, not the control precision
	task automatic t_overflow_flag_mem();
		reg_write(OFF_CTRL, 32'h0000_0001);
		run_op(DST_MEM, FMT_DBL, 16'h03ff, 67'h4_0000_0000_0000_0000);
		chk("mem dbl fits", 1'b0, overflow_flag_exc_q);
		chk("res_exp_q dbl", 15'h43fe, res_exp_q);
		run_op(DST_MEM, FMT_DBL, 16'h0400, 67'h4_0000_0000_0000_0000);
		chk("overflow_flag_exc_q mem", 1'b1, overflow_flag_exc_q);
		chk("res_wr_q mem", 1'b1, res_wr_q);
		chk("exc_post_q mem", 1'b1, exc_post_q);
		chk("res_dest_q mem", DST_MEM, res_dest_q);
		take_exc();
		run_op(DST_INTREG, FMT_EXT, 16'h4000, 67'h4_0000_0000_0000_0000);
		chk("overflow_flag_exc_q int", 1'b1, overflow_flag_exc_q);
		chk("exc_post_q int", 1'b1, exc_post_q);
		take_exc();
		reg_write(OFF_CTRL, 32'h0000_0000);
	endtask : t_overflow_flag_mem

	// non-float format out of range raises operand error, not overflow
	task automatic t_operand_error_exception();
		// earlier overflows left sticky bits behind
		reg_write(OFF_CLEAR, 32'h0000_0007);
		run_op(DST_FPREG, FMT_EXT, 16'hc000, 67'h4_0000_0000_0000_0000);
		chk("no overflow_flag on underflow", 1'b0, overflow_flag_exc_q);
		reg_read(OFF_STATUS, rd);
		chk("status unfl", 32'h0000_0002, rd);
		reg_write(OFF_CLEAR, 32'h0000_0007);
		op_cmd <= 16'ha5c3;
		op_ea <= 32'h1234_5678;
		op_iaddr <= 32'h0000_2468;
		run_op(DST_MEM, 3'h4, 16'h001e, 67'h4_0000_0000_0000_0000);
		chk("operand_error_exception below limit", 1'b0, operand_error_exception_exc_q);
		run_op(DST_MEM, 3'h4, 16'h001f, 67'h4_0000_0000_0000_0000);
		chk("operand_error_exception_exc_q mem", 1'b1, operand_error_exception_exc_q);
		chk("no overflow_flag on operand_error_exception", 1'b0, overflow_flag_exc_q);
		chk("frame_fmt_q mem", FRAME_FMT_OPERAND_ERROR_EXCEPTION, frame_fmt_q);
		take_exc();
		reg_read(OFF_CMD, rd);
		chk("saved command", 32'h0000_a5c3, rd);
		reg_read(OFF_EA, rd);
		chk("saved address", 32'h1234_5678, rd);
		reg_read(OFF_STATUS, rd);
		chk("status operand_error_exception", 32'h0000_0001, rd);
		run_op(DST_INTREG, 3'h4, 16'h001f, 67'h4_0000_0000_0000_0000);
		chk("operand_error_exception_exc_q int", 1'b1, operand_error_exception_exc_q);
		chk("frame_fmt_q int", FRAME_FMT_NONE, frame_fmt_q);
		take_exc();
		reg_read(OFF_IADDR, rd);
		chk("instruction address", 32'h0000_2468, rd);
	endtask : t_operand_error_exception

	// ----------------------------------------------------------------
	// verdict and watchdog
	// ----------------------------------------------------------------
	task automatic final_report();
		if (num_errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	// whole run is under two hundred cycles; generous ceiling
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			final_report();
		end
	end

	initial begin
		num_errors = 0;
		tests_run = 0;
		cycles = 0;
		rst = 1'b1;
		op_valid = 1'b0;
		op_sign = 1'b0;
		op_exp = 16'h0000;
		op_mant = '0;
		op_dest = DST_FPREG;
		op_fmt = FMT_EXT;
		op_cmd = 16'h0000;
		op_ea = 32'h0000_0000;
		op_iaddr = 32'h0000_0000;
		exc_ack = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
		t_reset();
		t_round();
		t_overflow_flag_reg();
		t_overflow_flag_mem();
		t_operand_error_exception();
		final_report();
	end

endmodule : fpu_intermediate_overflow_check_test
